// File: sscd_pkg.sv
package sscd_pkg;

    // Clock rate and the wait for the monitor input to open in run state
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MON_OPEN_MS = 100;
    localparam int unsigned MON_OPEN_CYC = MON_OPEN_MS * (CLK_HZ / 1000);

    // Register offsets (byte addresses) and reset values
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RESP = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0c;
    localparam logic [7:0] REG_DISP = 8'h10;
    localparam logic [7:0] REG_FAULT = 8'h14;
    localparam int CTRL_CLR_BIT = 0;
    localparam logic [3:0] RESP_RST = 4'h0;

    // Interrupt status bits
    localparam int IRQ_N = 3;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_CONTAM = 1;
    localparam int IRQ_RUN = 2;
    localparam logic [2:0] MASK_RST = 3'h0;

    // Pin synchroniser bits and their value after reset
    localparam int SY_MON = 0;
    localparam int SY_Z1 = 1;
    localparam int SY_Z2 = 2;
    localparam int SY_XRST = 3;
    localparam logic [3:0] SYNC_RST = 4'h1;

    // Response time digit: steps of 40 ms above 80 ms
    localparam logic [3:0] RESP_DIGIT_OFS = 4'h2;
    localparam logic [3:0] RESP_ZERO_STEP = 4'h8;

    // Character codes beyond 0..9
    localparam logic [3:0] CH_U = 4'ha;
    localparam logic [3:0] CH_BLANK = 4'hf;

    // Two-character display codes
    localparam logic [7:0] CODE_POWERUP = 8'h88;
    localparam logic [7:0] CODE_INTERLOCK = 8'h01;
    localparam logic [7:0] CODE_CONFIG = 8'h02;
    localparam logic [7:0] CODE_CONTAM = 8'h80;
    localparam logic [7:0] CODE_SSO_GEN = 8'h30;
    localparam logic [7:0] CODE_A_PWR = 8'h32;
    localparam logic [7:0] CODE_B_PWR = 8'h33;
    localparam logic [7:0] CODE_A_GND = 8'h34;
    localparam logic [7:0] CODE_B_GND = 8'h35;
    localparam logic [7:0] CODE_MON_GEN = 8'h40;
    localparam logic [7:0] CODE_MON_PRE = 8'h41;
    localparam logic [7:0] CODE_MON_POST = 8'h42;
    localparam logic [7:0] CODE_MON_PWR = 8'h43;
    localparam logic [7:0] CODE_XTALK = 8'h51;
    localparam logic [7:0] CODE_SHOCK = 8'h59;
    localparam logic [7:0] CODE_ZONE = 8'h70;
    localparam logic [7:0] CODE_DUSTVAR = 8'h81;
    localparam logic [3:0] INT_TENS = 4'h5;

    // Latched fault bits; the first five match the safety output fault inputs
    localparam int SSO_N = 5;
    localparam int F_SSO_GEN = 0;
    localparam int F_A_PWR = 1;
    localparam int F_B_PWR = 2;
    localparam int F_A_GND = 3;
    localparam int F_B_GND = 4;
    localparam int F_MON_GEN = 5;
    localparam int F_MON_PRE = 6;
    localparam int F_MON_POST = 7;
    localparam int F_MON_PWR = 8;
    localparam int F_INTERNAL = 9;
    localparam int F_XTALK = 10;
    localparam int F_SHOCK = 11;
    localparam int F_DUSTVAR = 12;
    localparam int F_ZONE = 13;
    localparam int FAULT_N = 14;

    // Whole state of the display block
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] filt;
        logic xrst_d;
        logic run_d;
        logic cont_d;
        logic mon_opened;
        logic [31:0] mon_cnt;
        logic [FAULT_N-1:0] faults;
        logic [3:0] int_digit;
        logic [3:0] resp;
        logic [IRQ_N-1:0] status;
        logic [IRQ_N-1:0] mask;
        logic [7:0] code;
        logic [6:0] seg_t;
        logic [6:0] seg_u;
        logic irq;
        logic [31:0] rdata;
    } sscd_state_t;

endpackage : sscd_pkg

// File: sscd_display.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Show operating status and any fault as a two-character code.
// - Show 88 at power-up, 01 when interlocked, 02 in configuration mode.
// - Show 80 when dust is detected on the exit window.
// - Output faults: 30 general, 32/33 A/B at supply, 34/35 A/B grounded.
// - Show 40 on monitor input miswiring.
// - Monitor input open when entering run state gives 41.
// - Monitor input still closed too long after entering run gives 42.
// - Monitor input open during power-up gives 43.
// - Show 51 on suspected crosstalk from another scanner.
// - Show 81 on dust circuit variance; it stays until restart.
// - Show 59 after shock; cleared by power cycle or external reset.
// - Show 70 on an invalid zone select input state.
// - In run state, first character is zone set, second is response time.
// - Zone character is 1, 2 or U for the union of both sets.
// - Time digit 2..9 for 80..360 ms in 40 ms steps, 0 from 400 ms.
module sscd_display #(
    parameter int unsigned MON_OPEN_CYCLES = sscd_pkg::MON_OPEN_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [sscd_pkg::ADDR_W-1:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [31:0] bus_rdata_out,
    output logic irq_out,
    // Operating state from the scanner core
    input wire logic powering_up_in,
    input wire logic interlock_wait_in,
    input wire logic configuration_mode_in,
    input wire logic run_state_in,
    input wire logic contamination_in,
    // Fault events from the scanner core
    input wire logic [sscd_pkg::SSO_N-1:0] safety_switching_output_fault_in,
    input wire logic external_device_monitor_miswire_in,
    input wire logic crosstalk_in,
    input wire logic shock_in,
    input wire logic dust_variance_in,
    input wire logic internal_fault_in,
    input wire logic [3:0] internal_fault_digit_in,
    // Pins
    input wire logic external_device_monitor_pin_in,
    input wire logic [1:0] zone_select_pin_in,
    input wire logic ext_reset_pin_in,
    // Seven-segment display, gfedcba, high lights a segment
    output logic [6:0] disp_tens_seg_out,
    output logic [6:0] disp_units_seg_out
);
    import sscd_pkg::*;

    sscd_state_t st_r;
    sscd_state_t st_nxt;
    logic mon_closed;
    logic xrst_rise;
    logic run_rise;
    logic soft_clr;
    logic stat_rd;
    logic [1:0] zone;
    logic [FAULT_N-1:0] f_set;
    logic [FAULT_N-1:0] f_clr;
    logic [IRQ_N-1:0] ev;
    logic [7:0] code;

    // Segment pattern of one character
    function automatic logic [6:0] sscd_seg(input logic [3:0] ch);
        case (ch)
            4'h0: return 7'h3f;
            4'h1: return 7'h06;
            4'h2: return 7'h5b;
            4'h3: return 7'h4f;
            4'h4: return 7'h66;
            4'h5: return 7'h6d;
            4'h6: return 7'h7d;
            4'h7: return 7'h07;
            4'h8: return 7'h7f;
            4'h9: return 7'h6f;
            CH_U: return 7'h3e;
            default: return 7'h00;
        endcase
    endfunction : sscd_seg

    // Response digit from the count of added 40 ms steps
    function automatic logic [3:0] sscd_resp_digit(input logic [3:0] steps);
        if (steps >= RESP_ZERO_STEP)
            return 4'h0;
        return 4'(steps + RESP_DIGIT_OFS);
    endfunction : sscd_resp_digit

    // Zone character from the filtered zone select pins
    function automatic logic [3:0] sscd_zone_char(input logic [1:0] z);
        case (z)
            2'b01: return 4'h1;
            2'b10: return 4'h2;
            2'b11: return CH_U;
            default: return CH_BLANK;
        endcase
    endfunction : sscd_zone_char

    // Highest priority latched fault as a code
    function automatic logic [7:0] sscd_fault_code(input logic [FAULT_N-1:0] f,
                                                   input logic [3:0] d);
        if (f[F_DUSTVAR])
            return CODE_DUSTVAR;
        if (f[F_SHOCK])
            return CODE_SHOCK;
        if (f[F_A_PWR])
            return CODE_A_PWR;
        if (f[F_B_PWR])
            return CODE_B_PWR;
        if (f[F_A_GND])
            return CODE_A_GND;
        if (f[F_B_GND])
            return CODE_B_GND;
        if (f[F_SSO_GEN])
            return CODE_SSO_GEN;
        if (f[F_MON_PWR])
            return CODE_MON_PWR;
        if (f[F_MON_PRE])
            return CODE_MON_PRE;
        if (f[F_MON_POST])
            return CODE_MON_POST;
        if (f[F_MON_GEN])
            return CODE_MON_GEN;
        if (f[F_INTERNAL])
            return {INT_TENS, d};
        if (f[F_XTALK])
            return CODE_XTALK;
        return CODE_ZONE;
    endfunction : sscd_fault_code

    // Next state of the whole block
    always_comb
    begin
        st_nxt = st_r;
        // Three-stage pin synchronisers; a bit changes once stages two and three agree
        st_nxt.s1 = {ext_reset_pin_in, zone_select_pin_in, external_device_monitor_pin_in};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < 4; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
                st_nxt.filt[i] = st_r.s3[i];
        end
        mon_closed = st_r.filt[SY_MON];
        zone = {st_r.filt[SY_Z2], st_r.filt[SY_Z1]};
        xrst_rise = st_r.filt[SY_XRST] & ~st_r.xrst_d;
        run_rise = run_state_in & ~st_r.run_d;
        st_nxt.xrst_d = st_r.filt[SY_XRST];
        st_nxt.run_d = run_state_in;
        st_nxt.cont_d = contamination_in;
        soft_clr = bus_wr_in && (bus_addr_in == REG_CTRL) && bus_wdata_in[CTRL_CLR_BIT];
        stat_rd = bus_rd_in && (bus_addr_in == REG_STATUS);

        // Monitor input must open within the wait after run entry
        if (!run_state_in)
            st_nxt.mon_opened = 1'b0;
        else if (!mon_closed)
            st_nxt.mon_opened = 1'b1;
        if (!run_state_in || st_r.mon_opened)
            st_nxt.mon_cnt = 32'h0;
        else if (mon_closed && st_r.mon_cnt != 32'(MON_OPEN_CYCLES - 1))
            st_nxt.mon_cnt = st_r.mon_cnt + 32'h1;

        // Fault sources
        f_set = '0;
        f_set[SSO_N-1:0] = safety_switching_output_fault_in;
        f_set[F_MON_GEN] = external_device_monitor_miswire_in;
        f_set[F_MON_PRE] = run_rise & ~mon_closed;
        f_set[F_MON_POST] = run_state_in & ~st_r.mon_opened & mon_closed
            & (st_r.mon_cnt == 32'(MON_OPEN_CYCLES - 1));
        f_set[F_MON_PWR] = powering_up_in & ~mon_closed;
        f_set[F_XTALK] = crosstalk_in;
        f_set[F_DUSTVAR] = dust_variance_in;
        f_set[F_SHOCK] = shock_in;
        f_set[F_ZONE] = ~powering_up_in & (zone == 2'b00);
        f_set[F_INTERNAL] = internal_fault_in;

        // Software clear spares shock and dust variance; the reset pin spares only variance
        f_clr = '0;
        if (soft_clr)
        begin
            f_clr = '1;
            f_clr[F_SHOCK] = 1'b0;
            f_clr[F_DUSTVAR] = 1'b0;
        end
        if (xrst_rise)
        begin
            f_clr = '1;
            f_clr[F_DUSTVAR] = 1'b0;
        end
        st_nxt.faults = (st_r.faults & ~f_clr) | f_set;

        // Internal fault digit; 1, 9 and above 8 fall back to 50
        if (internal_fault_in && !st_r.faults[F_INTERNAL])
        begin
            if (internal_fault_digit_in == 4'h1 || internal_fault_digit_in > 4'h8)
                st_nxt.int_digit = 4'h0;
            else
                st_nxt.int_digit = internal_fault_digit_in;
        end

        // Register writes
        if (bus_wr_in && bus_addr_in == REG_RESP)
            st_nxt.resp = bus_wdata_in[3:0];
        if (bus_wr_in && bus_addr_in == REG_MASK)
            st_nxt.mask = bus_wdata_in[IRQ_N-1:0];

        // Sticky events; a new event wins over the read that clears
        ev[IRQ_FAULT] = |(f_set & ~st_r.faults);
        ev[IRQ_CONTAM] = contamination_in & ~st_r.cont_d;
        ev[IRQ_RUN] = run_rise;
        st_nxt.status = (stat_rd ? '0 : st_r.status) | ev;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);

        // Display code selection
        if (powering_up_in)
            code = CODE_POWERUP;
        else if (|st_r.faults)
            code = sscd_fault_code(st_r.faults, st_r.int_digit);
        else if (configuration_mode_in)
            code = CODE_CONFIG;
        else if (contamination_in)
            code = CODE_CONTAM;
        else if (interlock_wait_in)
            code = CODE_INTERLOCK;
        else
            code = {sscd_zone_char(zone), sscd_resp_digit(st_r.resp)};
        st_nxt.code = code;
        st_nxt.seg_t = sscd_seg(code[7:4]);
        st_nxt.seg_u = sscd_seg(code[3:0]);

        // Read data stands only in the cycle after the strobe
        st_nxt.rdata = 32'h0;
        if (bus_rd_in)
        begin
            case (bus_addr_in)
                REG_RESP: st_nxt.rdata = {28'h0, st_r.resp};
                REG_STATUS: st_nxt.rdata = {29'h0, st_r.status};
                REG_MASK: st_nxt.rdata = {29'h0, st_r.mask};
                REG_DISP: st_nxt.rdata = {24'h0, st_r.code};
                REG_FAULT: st_nxt.rdata = {18'h0, st_r.faults};
                default: st_nxt.rdata = 32'h0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r <= '0;
            st_r.s1 <= SYNC_RST;
            st_r.s2 <= SYNC_RST;
            st_r.s3 <= SYNC_RST;
            st_r.filt <= SYNC_RST;
            st_r.resp <= RESP_RST;
            st_r.mask <= MASK_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign bus_rdata_out = st_r.rdata;
    assign irq_out = st_r.irq;
    assign disp_tens_seg_out = st_r.seg_t;
    assign disp_units_seg_out = st_r.seg_u;

    // Checks on the displayed code and the fault latches
    chk_powerup_code: assert property (@(posedge clk_in) disable iff (rst_in)
        powering_up_in |=> st_r.code == CODE_POWERUP && st_r.seg_t == 7'h7f)
        else $error("power-up code not shown");

    chk_config_code: assert property (@(posedge clk_in) disable iff (rst_in)
        !powering_up_in && st_r.faults == '0 && configuration_mode_in
        |=> st_r.code == CODE_CONFIG)
        else $error("configuration code not shown");

    chk_contam_code: assert property (@(posedge clk_in) disable iff (rst_in)
        !powering_up_in && st_r.faults == '0 && !configuration_mode_in && contamination_in
        |=> st_r.code == CODE_CONTAM)
        else $error("contamination code not shown");

    chk_output_fault: assert property (@(posedge clk_in) disable iff (rst_in)
        safety_switching_output_fault_in[F_A_PWR] && !powering_up_in
        |=> st_r.faults[F_A_PWR] ##1 st_r.code != CODE_CONTAM)
        else $error("output fault not latched or shown");

    chk_mon_entry: assert property (@(posedge clk_in) disable iff (rst_in)
        run_state_in && !$past(run_state_in) && !st_r.filt[SY_MON]
        |=> st_r.faults[F_MON_PRE])
        else $error("monitor open at run entry not flagged");

    chk_mon_powerup: assert property (@(posedge clk_in) disable iff (rst_in)
        powering_up_in && !st_r.filt[SY_MON] |=> st_r.faults[F_MON_PWR])
        else $error("monitor open at power-up not flagged");

    chk_dustvar_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r.faults[F_DUSTVAR] |=> st_r.faults[F_DUSTVAR])
        else $error("dust variance fault cleared before restart");

    chk_shock_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r.faults[F_SHOCK] && !shock_in && st_r.filt[SY_XRST] && !st_r.xrst_d
        |=> !st_r.faults[F_SHOCK])
        else $error("shock fault not cleared by reset pin");

    chk_fault_shown: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r.faults[F_DUSTVAR] && !powering_up_in |=> st_r.code == CODE_DUSTVAR)
        else $error("latched fault not shown in preference");

    chk_union_slow: assert property (@(posedge clk_in) disable iff (rst_in)
        !powering_up_in && st_r.faults == '0 && !configuration_mode_in && !contamination_in
        && !interlock_wait_in && st_r.filt[SY_Z2:SY_Z1] == 2'b11 && st_r.resp >= 4'h8
        |=> st_r.code == {CH_U, 4'h0} && st_r.seg_u == 7'h3f)
        else $error("run code wrong for union and long response");

    chk_interlock_code: assert property (@(posedge clk_in) disable iff (rst_in)
        !powering_up_in && st_r.faults == '0 && !configuration_mode_in && !contamination_in
        && interlock_wait_in |=> st_r.code == CODE_INTERLOCK)
        else $error("interlock code not shown");

    chk_sso_general: assert property (@(posedge clk_in) disable iff (rst_in)
        safety_switching_output_fault_in[F_SSO_GEN] |=> st_r.faults[F_SSO_GEN])
        else $error("general output fault not latched");

    chk_mon_miswire: assert property (@(posedge clk_in) disable iff (rst_in)
        external_device_monitor_miswire_in |=> st_r.faults[F_MON_GEN])
        else $error("monitor miswire fault not latched");

    chk_mon_late_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        !run_state_in && !st_r.faults[F_MON_POST] |=> !st_r.faults[F_MON_POST])
        else $error("late monitor fault raised outside run state");

    chk_xtalk_latch: assert property (@(posedge clk_in) disable iff (rst_in)
        crosstalk_in |=> st_r.faults[F_XTALK])
        else $error("crosstalk fault not latched");

    chk_shock_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r.faults[F_SHOCK] && !(st_r.filt[SY_XRST] && !st_r.xrst_d)
        |=> st_r.faults[F_SHOCK])
        else $error("shock fault cleared without reset pin");

    chk_zone_invalid: assert property (@(posedge clk_in) disable iff (rst_in)
        !powering_up_in && st_r.filt[SY_Z2:SY_Z1] == 2'b00 |=> st_r.faults[F_ZONE])
        else $error("invalid zone select not flagged");

    chk_zone_one: assert property (@(posedge clk_in) disable iff (rst_in)
        !powering_up_in && st_r.faults == '0 && !configuration_mode_in && !contamination_in
        && !interlock_wait_in && st_r.filt[SY_Z2:SY_Z1] == 2'b01 |=> st_r.code[7:4] == 4'h1)
        else $error("run code wrong for zone set one");

    chk_resp_digit: assert property (@(posedge clk_in) disable iff (rst_in)
        !powering_up_in && st_r.faults == '0 && !configuration_mode_in && !contamination_in
        && !interlock_wait_in && st_r.resp < 4'h8
        |=> st_r.code[3:0] == 4'($past(st_r.resp) + 4'h2))
        else $error("response digit wrong");

    chk_internal_digit: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r.faults[F_INTERNAL] |-> st_r.int_digit != 4'h1 && st_r.int_digit != 4'h9)
        else $error("internal fault digit clashes with another code");

endmodule : sscd_display

`default_nettype wire

// File: sscd_panel.sv
`timescale 1ns/1ps
`default_nettype none

// Operator reading the two digits; an unlit or garbled glyph reads as f or e
module sscd_panel (
    // Segments, gfedcba
    input wire logic [6:0] tens_seg_in,
    input wire logic [6:0] units_seg_in,
    // Characters read, a for U
    output logic [3:0] tens_ch_out,
    output logic [3:0] units_ch_out
);
    // Turns a glyph back into its character
    function automatic logic [3:0] glyph(input logic [6:0] s);
        case (s)
            7'h3f: glyph = 4'h0;
            7'h06: glyph = 4'h1;
            7'h5b: glyph = 4'h2;
            7'h4f: glyph = 4'h3;
            7'h66: glyph = 4'h4;
            7'h6d: glyph = 4'h5;
            7'h7d: glyph = 4'h6;
            7'h07: glyph = 4'h7;
            7'h7f: glyph = 4'h8;
            7'h6f: glyph = 4'h9;
            7'h3e: glyph = 4'ha;
            7'h00: glyph = 4'hf;
            default: glyph = 4'he;
        endcase
    endfunction : glyph

    // Both digits read at all times, tens first
    always_comb
    begin
        tens_ch_out = glyph(tens_seg_in);
        units_ch_out = glyph(units_seg_in);
    end
endmodule : sscd_panel
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import sscd_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic irq, pu = 1'b1, ilk = 1'b0, cfg = 1'b0, run = 1'b0, cont = 1'b0;
    logic [4:0] sso = 5'h0;
    logic miswire = 1'b0, xtalk = 1'b0, shock = 1'b0, dust = 1'b0, intf = 1'b0;
    logic [3:0] intd = 4'h0, ch_t, ch_u;
    logic mon_pin = 1'b1, xrst = 1'b0;
    logic [1:0] zone = 2'h1;
    logic [6:0] seg_t, seg_u;
    int n_errors = 0;
    int check_count = 0;

    // Clock at 20 MHz
    always #25 clk_in = ~clk_in;

    // Block under test, short run-state wait
    sscd_display #(.MON_OPEN_CYCLES(16)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
        .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .irq_out(irq),
        .powering_up_in(pu), .interlock_wait_in(ilk), .configuration_mode_in(cfg),
        .run_state_in(run), .contamination_in(cont),
        .safety_switching_output_fault_in(sso), .external_device_monitor_miswire_in(miswire),
        .crosstalk_in(xtalk), .shock_in(shock), .dust_variance_in(dust),
        .internal_fault_in(intf), .internal_fault_digit_in(intd),
        .external_device_monitor_pin_in(mon_pin), .zone_select_pin_in(zone),
        .ext_reset_pin_in(xrst), .disp_tens_seg_out(seg_t), .disp_units_seg_out(seg_u)
    );

    // Operator reading the display
    sscd_panel u_panel (.tens_seg_in(seg_t), .units_seg_in(seg_u),
        .tens_ch_out(ch_t), .units_ch_out(ch_u));

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk

    task automatic chk_disp(input logic [7:0] exp);
        chk("display", {24'h0, exp}, {24'h0, ch_t, ch_u});
    endtask : chk_disp

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the read edge
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : bus_rd

    task automatic xreset();
        xrst <= 1'b1;
        step(8);
        xrst <= 1'b0;
        step(8);
    endtask : xreset

    task automatic t_powerup();
        chk_disp(8'h88);
        mon_pin <= 1'b0;
        step(8);
        mon_pin <= 1'b1;
        step(8);
        pu <= 1'b0;
        step(3);
        chk_disp(8'h43);
        chk("masked irq", 32'h0, {31'h0, irq});
        bus_rd(REG_FAULT, d);
        chk("fault reg", 32'h100, d);
        bus_wr(REG_CTRL, 32'h1);
        step(3);
        chk_disp(8'h12);
    endtask : t_powerup

    task automatic t_regs();
        bus_rd(REG_RESP, d);
        chk("resp reset", 32'h0, d);
        bus_rd(REG_MASK, d);
        chk("mask reset", 32'h0, d);
        bus_wr(REG_RESP, 32'h5);
        bus_wr(8'h20, 32'hffff);
        bus_wr(REG_DISP, 32'h99);
        bus_rd(REG_RESP, d);
        chk("resp", 32'h5, d);
        bus_rd(8'h20, d);
        chk("unmapped", 32'h0, d);
        bus_rd(REG_DISP, d);
        chk("disp reg", 32'h17, d);
        bus_wr(REG_RESP, 32'h0);
    endtask : t_regs

    task automatic t_states();
        bus_rd(REG_STATUS, d);
        bus_wr(REG_MASK, 32'h2);
        ilk <= 1'b1;
        step(3);
        chk_disp(8'h01);
        cont <= 1'b1;
        step(3);
        chk_disp(8'h80);
        chk("irq", 32'h1, {31'h0, irq});
        bus_rd(REG_STATUS, d);
        chk("status", 32'h2, d);
        step(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        cfg <= 1'b1;
        step(3);
        chk_disp(8'h02);
        {ilk, cont, cfg} <= 3'h0;
    endtask : t_states

    task automatic t_run();
        logic [3:0] rv [4] = '{4'h0, 4'h7, 4'h8, 4'hf};
        logic [3:0] dch [4] = '{4'h2, 4'h9, 4'h0, 4'h0};
        logic [3:0] zch [4] = '{4'hf, 4'h1, 4'h2, 4'ha};
        run <= 1'b1;
        step(2);
        bus_rd(REG_STATUS, d);
        chk("run entry event", 32'h4, d);
        mon_pin <= 1'b0;
        for (int z = 1; z < 4; z++)
            for (int r = 0; r < 4; r++)
            begin
                bus_wr(REG_RESP, {28'h0, rv[r]});
                zone <= 2'(z);
                step(8);
                chk_disp({zch[z], dch[r]});
            end
        run <= 1'b0;
        mon_pin <= 1'b1;
        zone <= 2'h1;
        bus_wr(REG_RESP, 32'h0);
        step(8);
        chk_disp(8'h12);
    endtask : t_run

    task automatic t_mon();
        mon_pin <= 1'b0;
        step(8);
        run <= 1'b1;
        step(4);
        chk_disp(8'h41);
        bus_rd(REG_FAULT, d);
        chk("fault reg", 32'h40, d);
        run <= 1'b0;
        mon_pin <= 1'b1;
        step(8);
        bus_wr(REG_CTRL, 32'h1);
        run <= 1'b1;
        step(12);
        chk_disp(8'h12);
        step(18);
        chk_disp(8'h42);
        bus_rd(REG_FAULT, d);
        chk("fault reg", 32'h80, d);
        run <= 1'b0;
        bus_wr(REG_CTRL, 32'h1);
    endtask : t_mon

    task automatic t_faults();
        logic [7:0] codes [10] = '{8'h30, 8'h32, 8'h33, 8'h34, 8'h35,
            8'h40, 8'h51, 8'h53, 8'h50, 8'h70};
        for (int i = 0; i < 10; i++)
        begin
            sso <= (i < 5) ? 5'(5'h1 << i) : 5'h0;
            miswire <= (i == 5);
            xtalk <= (i == 6);
            intf <= (i == 7 || i == 8);
            intd <= (i == 7) ? 4'h3 : 4'h9;
            zone <= (i == 9) ? 2'h0 : 2'h1;
            step(8);
            {sso, miswire, xtalk, intf} <= 8'h0;
            zone <= 2'h1;
            step(8);
            chk_disp(codes[i]);
            bus_wr(REG_CTRL, 32'h1);
            step(3);
            chk_disp(8'h12);
        end
    endtask : t_faults

    task automatic t_shock();
        bus_wr(REG_MASK, 32'h1);
        bus_rd(REG_STATUS, d);
        shock <= 1'b1;
        step(1);
        shock <= 1'b0;
        step(3);
        chk_disp(8'h59);
        chk("irq", 32'h1, {31'h0, irq});
        bus_rd(REG_STATUS, d);
        chk("status", 32'h1, d);
        cont <= 1'b1;
        bus_wr(REG_CTRL, 32'h1);
        step(3);
        chk_disp(8'h59);
        xreset();
        chk_disp(8'h80);
        cont <= 1'b0;
    endtask : t_shock

    task automatic t_dust();
        dust <= 1'b1;
        step(1);
        dust <= 1'b0;
        step(3);
        chk_disp(8'h81);
        bus_wr(REG_CTRL, 32'h1);
        xreset();
        chk_disp(8'h81);
        rst_in <= 1'b1;
        pu <= 1'b1;
        step(10);
        rst_in <= 1'b0;
        step(8);
        chk_disp(8'h88);
        pu <= 1'b0;
        step(4);
        chk_disp(8'h12);
    endtask : t_dust

    task automatic end_sim();
        $display("errors %0d, checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #2_000_000;
        n_errors++;
        end_sim();
    end

    // Reset, then the scenarios in turn
    initial
    begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        step(8);
        t_powerup();
        t_regs();
        t_states();
        t_run();
        t_mon();
        t_faults();
        t_shock();
        t_dust();
        end_sim();
    end
endmodule : tb
`default_nettype wire
